// *** asr_adc_serial.sv ***
// Behaviour
// - Eight-bit word 1XXXXX11 starts an external clock conversion.
// - Strobe falling edge marks conversion running and result bits coming.
// - Sixteen bits follow the strobe: fourteen result bits then two trailing.
// - Chip select high deselects; serial activity ignored until it falls again.
// - Output changes on falling clock edges; host captures on rising edges.

// ************************************************************
// Serial conversion readout, external clock mode
// ************************************************************
module asr_adc_serial #(
    parameter int RESULT_W = asr_pkg::RESULT_BITS,
    parameter int DEPTH    = asr_pkg::FIFO_DEPTH
) (
    input  wire logic                mclk,
    input  wire logic                resetn,
    input  wire logic                cs_n,
    input  wire logic                sclk,
    input  wire logic                din,
    output logic                     dout,
    output logic                     conversion_strobe_out,
    input  wire logic                sample_valid,
    input  wire logic [RESULT_W-1:0] sample_data,
    output logic                     sample_ready,
    output logic                     result_missing
);

    // ************************************************************
    // Result buffer
    // ************************************************************
    asr_stream_if #(.WIDTH(RESULT_W)) in_s ();
    asr_stream_if #(.WIDTH(RESULT_W)) out_s ();

    assign in_s.valid = sample_valid;
    assign in_s.data  = sample_data;

    asr_fifo #(.WIDTH(RESULT_W), .DEPTH(DEPTH)) u_fifo (
        .mclk   (mclk),
        .resetn (resetn),
        .wr     (in_s.snk),
        .rd     (out_s.src)
    );

    // ************************************************************
    // Link state
    // ************************************************************
    typedef struct packed {
        asr_pkg::asr_phase_type phase;
        logic                   sclk_q;
        logic [7:0]             word;
        logic [4:0]             bitcnt;
        logic [RESULT_W-1:0]    result;
        logic                   strobe;
        logic                   dout;
        logic                   missing;
    } asr_state_type;

    asr_state_type s;
    asr_state_type next_s;
    logic          rise;
    logic          fall;
    logic [7:0]    shifted;
    logic          pop;

    // Inputs are synchronous to mclk, so one flop of history finds edges
    assign rise    = sclk && !s.sclk_q;
    assign fall    = !sclk && s.sclk_q;
    assign shifted = {s.word[6:0], din};

    // Sequencer
    always_comb
    begin
        next_s = s;
        pop = 1'b0;
        next_s.sclk_q = sclk;
        next_s.missing = 1'b0;
        if (cs_n)
        begin
            // Deselected: drop any frame, quiet outputs
            next_s.phase = asr_pkg::PH_IDLE;
            next_s.bitcnt = '0;
            next_s.word = '0;
            next_s.strobe = 1'b0;
            next_s.dout = 1'b0;
        end
        else
        begin
            unique case (s.phase)
                asr_pkg::PH_IDLE, asr_pkg::PH_CMD:
                begin
                    next_s.phase = asr_pkg::PH_CMD;
                    if (rise)
                    begin
                        next_s.word = shifted;
                        next_s.bitcnt = s.bitcnt + 5'h01;
                        if (s.bitcnt == asr_pkg::CMD_LAST_IDX)
                        begin
                            next_s.bitcnt = '0;
                            // Other words are taken and dropped; the next word follows
                            if ((shifted & asr_pkg::START_MASK) == asr_pkg::START_CODE)
                            begin
                                next_s.phase = asr_pkg::PH_STRB;
                                next_s.strobe = 1'b1;
                                pop = out_s.valid;
                                next_s.result = out_s.valid ? out_s.data : '0;
                                next_s.missing = !out_s.valid;
                            end
                        end
                    end
                end
                asr_pkg::PH_STRB:
                begin
                    // Strobe falls with the first result bit
                    if (fall)
                    begin
                        next_s.strobe = 1'b0;
                        next_s.dout = s.result[RESULT_W-1];
                        next_s.result = {s.result[RESULT_W-2:0], 1'b0};
                        next_s.phase = asr_pkg::PH_DATA;
                    end
                end
                asr_pkg::PH_DATA:
                begin
                    // One decision per host clock; zero fill gives the trailing bits
                    if (fall)
                    begin
                        next_s.dout = s.result[RESULT_W-1];
                        next_s.result = {s.result[RESULT_W-2:0], 1'b0};
                    end
                    if (rise)
                    begin
                        next_s.bitcnt = s.bitcnt + 5'h01;
                        if (s.bitcnt == asr_pkg::FRAME_LAST)
                            next_s.phase = asr_pkg::PH_DONE;
                    end
                end
                asr_pkg::PH_DONE:
                begin
                    // Wait for chip select to rise
                    if (fall)
                        next_s.dout = 1'b0;
                end
            endcase
        end
    end

    assign out_s.ready = pop;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            s <= '0;
            s.phase <= asr_pkg::PH_IDLE;
        end
        else
            s <= next_s;
    end

    assign dout = s.dout;
    assign conversion_strobe_out = s.strobe;
    // FIFO flag is a flop; a copy one cycle late would show full words as taken
    assign sample_ready = in_s.ready;
    assign result_missing = s.missing;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence seq_strobe_drop;
        s.strobe ##1 !s.strobe;
    endsequence

    AST_START_WORD: assert property (@(posedge mclk) disable iff (!resetn)
        (!cs_n && rise && s.bitcnt == asr_pkg::CMD_LAST_IDX
         && (s.phase == asr_pkg::PH_CMD)
         && ((shifted & asr_pkg::START_MASK) == asr_pkg::START_CODE))
        |=> (s.strobe && s.phase == asr_pkg::PH_STRB))
        else $error("start word did not raise strobe");

    AST_MISSING_START: assert property (@(posedge mclk) disable iff (!resetn)
        s.missing |-> (s.strobe && s.phase == asr_pkg::PH_STRB && s.result == '0))
        else $error("missing flag without start word");

    AST_STROBE_FALL: assert property (@(posedge mclk) disable iff (!resetn)
        (s.strobe && fall && !cs_n) |=> (!s.strobe && s.phase == asr_pkg::PH_DATA))
        else $error("strobe did not fall on clock fall");

    AST_DROP_DATA: assert property (@(posedge mclk) disable iff (!resetn)
        seq_strobe_drop |-> (s.phase == asr_pkg::PH_DATA || s.phase == asr_pkg::PH_IDLE))
        else $error("strobe fell outside data start");

    AST_FRAME_END: assert property (@(posedge mclk) disable iff (!resetn)
        (!cs_n && rise && s.phase == asr_pkg::PH_DATA && s.bitcnt == asr_pkg::FRAME_LAST)
        |=> (s.phase == asr_pkg::PH_DONE && s.bitcnt == 5'h10))
        else $error("frame not closed after sixteen bits");

    AST_DESELECT: assert property (@(posedge mclk) disable iff (!resetn)
        cs_n |=> (s.phase == asr_pkg::PH_IDLE && !s.strobe && !s.dout))
        else $error("deselect left link active");

    AST_DOUT_EDGE: assert property (@(posedge mclk) disable iff (!resetn)
        (!cs_n && !fall) |=> $stable(s.dout))
        else $error("dout moved without falling clock");

    AST_SAR_BIT: assert property (@(posedge mclk) disable iff (!resetn)
        (!cs_n && fall && s.phase == asr_pkg::PH_DATA)
        |=> (s.dout == $past(s.result[RESULT_W-1])))
        else $error("result bit not stepped on host clock");

endmodule // asr_adc_serial

// *** asr_fifo.sv ***
// ************************************************************
// Result FIFO, power-of-two depth
// ************************************************************
module asr_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = asr_pkg::FIFO_DEPTH
) (
    input  wire logic mclk,
    input  wire logic resetn,
    asr_stream_if.snk wr,
    asr_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wptr;
        logic [AW:0]                 rptr;
        logic                        can_accept;
        logic                        has_data;
    } asr_fifo_state_type;

    asr_fifo_state_type s;
    asr_fifo_state_type next_s;
    logic [AW:0]        next_count;

    // Flags are registered so the top's ready output comes from a flop
    always_comb
    begin
        next_s = s;
        if (wr.valid && s.can_accept)
        begin
            next_s.mem[s.wptr[AW-1:0]] = wr.data;
            next_s.wptr = s.wptr + 1'b1;
        end
        if (rd.ready && s.has_data)
            next_s.rptr = s.rptr + 1'b1;
        next_count = next_s.wptr - next_s.rptr;
        next_s.can_accept = (next_count != DEPTH[AW:0]);
        next_s.has_data = (next_count != '0);
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            s <= '0;
            s.can_accept <= 1'b1;
        end
        else
            s <= next_s;
    end

    assign wr.ready = s.can_accept;
    assign rd.valid = s.has_data;
    assign rd.data  = s.mem[s.rptr[AW-1:0]];

    // Occupancy never passes the depth
    AST_FIFO_BOUND: assert property (@(posedge mclk) disable iff (!resetn)
        (AW+1)'(s.wptr - s.rptr) <= DEPTH[AW:0])
        else $error("fifo occupancy beyond depth");

endmodule // asr_fifo

// *** asr_host_model.sv ***
// ************************************************************
// Host serial master model, clock idles low between frames
// ************************************************************
module asr_host_model #(
    parameter int HALF = 24
) (
    input  wire logic        mclk,
    input  wire logic        dout,
    input  wire logic        strobe,
    output logic             cs_n,
    output logic             sclk,
    output logic             din,
    output logic [15:0]      result,
    output logic [1:0]       strb_pair,
    output logic             done
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle levels; a released data line shows the inverse of its last bit
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
        result = 16'h0000;
        strb_pair = 2'h0;
        done = 1'b0;
    end

    // Half period of 24 cycles keeps the clock under 2.1 MHz
    task automatic half();
        repeat (HALF) @(negedge mclk);
    endtask

    // Select first, then eight bits MSB first, each taken on a rise
    task automatic put_cmd(input logic [7:0] cmd);
        int i;
        cs_n = 1'b0;
        half();
        for (i = 7; i >= 0; i--)
        begin
            sclk = 1'b0;
            din = cmd[i];
            half();
            sclk = 1'b1;
            half();
        end
        din = ~din;
    endtask

    // Word, one fall to start the result, then sixteen captures on rises
    task automatic convert(input logic [7:0] cmd);
        int k;
        put_cmd(cmd);
        strb_pair[1] = strobe;
        sclk = 1'b0;
        half();
        strb_pair[0] = strobe;
        for (k = 15; k >= 0; k--)
        begin
            result[k] = dout;
            sclk = 1'b1;
            half();
            sclk = 1'b0;
            half();
        end
        cs_n = 1'b1;
        done = 1'b1;
        @(negedge mclk);
        done = 1'b0;
        half();
    endtask

    // Word and one clock fall, then deselect
    task automatic refuse(input logic [7:0] cmd);
        put_cmd(cmd);
        // Strobe is caught while still selected; deselect would hide it
        strb_pair[1] = strobe;
        sclk = 1'b0;
        half();
        strb_pair[0] = strobe;
        cs_n = 1'b1;
        half();
    endtask

    // Clock toggling with data held high while deselected must be ignored
    task automatic idle_clock();
        int i;
        din = 1'b1;
        for (i = 0; i < 8; i++)
        begin
            sclk = 1'b1;
            half();
            sclk = 1'b0;
            half();
        end
    endtask
endmodule // asr_host_model

// *** asr_pkg.sv ***
// ************************************************************
// Shared constants for the serial conversion readout
// ************************************************************
package asr_pkg;

    // Frame geometry
    localparam int          CMD_BITS      = 8;
    localparam int          RESULT_BITS   = 14;
    localparam int          FRAME_BITS    = 16;
    localparam logic [4:0]  CMD_LAST_IDX  = 5'h07;
    localparam logic [4:0]  FRAME_LAST    = 5'h0f;

    // Start word 1XXXXX11: bit 7 and bits 1:0 must be one
    localparam logic [7:0]  START_MASK    = 8'h83;
    localparam logic [7:0]  START_CODE    = 8'h83;

    // Result buffer
    localparam int          FIFO_DEPTH    = 32;

    // Highest serial clock the host may run, in kHz
    localparam int          SCLK_MAX_KHZ  = 2100;

    // Link phases, one-hot
    typedef enum logic [4:0]
    {
        PH_IDLE = 5'h01,
        PH_CMD  = 5'h02,
        PH_STRB = 5'h04,
        PH_DATA = 5'h08,
        PH_DONE = 5'h10
    } asr_phase_type;

endpackage

// *** asr_stream_if.sv ***
// ************************************************************
// Valid/ready word stream between the block's own modules
// ************************************************************
interface asr_stream_if #(parameter int WIDTH = 14);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// *** tb.sv ***
// ************************************************************
// Testbench: result FIFO feeding the serial readout
// ************************************************************
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk, resetn, cs_n, sclk, din, dout, strobe, done, miss_seen;
    logic        sample_valid, sample_ready, result_missing;
    logic [13:0] sample_data;
    logic [15:0] result;
    logic [1:0]  strb_pair;
    logic [31:0] seed;
    logic [14:0] note;
    logic [14:0] expq[$];
    int          fails, check_count, i;

    asr_adc_serial #(.RESULT_W(asr_pkg::RESULT_BITS), .DEPTH(asr_pkg::FIFO_DEPTH)) dut (
        .mclk(mclk), .resetn(resetn), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
        .conversion_strobe_out(strobe), .sample_valid(sample_valid),
        .sample_data(sample_data), .sample_ready(sample_ready),
        .result_missing(result_missing));

    asr_host_model host (
        .mclk(mclk), .dout(dout), .strobe(strobe), .cs_n(cs_n), .sclk(sclk),
        .din(din), .result(result), .strb_pair(strb_pair), .done(done));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ************************************************************
    // Clock, watchdog and result monitor
    // ************************************************************
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // About 42k cycles expected; cut off well beyond
    initial
    begin
        #900000;
        fails++;
        $display("Error watchdog expired");
        report_and_stop();
    end

    // Oldest note against each finished frame; trailing bits dropped
    always @(posedge mclk)
    begin
        if (result_missing === 1'b1)
            miss_seen = 1'b1;
        if (done === 1'b1)
        begin
            note = (expq.size() > 0) ? expq.pop_front() : 15'h7fff;
            chk("result", {1'b0, note}, {1'b0, miss_seen, result[15:2]});
            chk("strobe", 16'h0002, {14'h0, strb_pair});
            miss_seen = 1'b0;
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        resetn = 1'b0;
        sample_valid = 1'b0;
        sample_data = 14'h0000;
        seed = 32'h00000002;
        miss_seen = 1'b0;
        fails = 0;
        check_count = 0;
        repeat (12) @(negedge mclk);
        resetn = 1'b1;
        repeat (2) @(negedge mclk);
        chk("ready", 16'h1, {15'h0, sample_ready});
        host.idle_clock();
        chk("strobe idle", 16'h0, {15'h0, strobe});
        chk("dout idle", 16'h0, {15'h0, dout});
        chk("missing idle", 16'h0, {15'h0, miss_seen});
        host.refuse(8'h82);
        chk("strobe refused", 16'h0, {14'h0, strb_pair});
        host.refuse(8'h03);
        chk("strobe refused", 16'h0, {14'h0, strb_pair});
        // Empty buffer: zeros and a missing flag
        expq.push_back(15'h4000);
        host.convert(8'h83);
        // Fill the buffer until it refuses
        for (i = 0; i < 32; i++)
        begin
            seed = xs(seed);
            chk("ready fill", 16'h1, {15'h0, sample_ready});
            sample_valid = 1'b1;
            sample_data = seed[13:0];
            @(negedge mclk);
            sample_valid = 1'b0;
            expq.push_back({1'b0, seed[13:0]});
            repeat (2) @(negedge mclk);
        end
        chk("ready full", 16'h0, {15'h0, sample_ready});
        // Drain with random middle bits in every start word
        for (i = 0; i < 32; i++)
        begin
            seed = xs(seed);
            host.convert({1'b1, seed[4:0], 2'b11});
        end
        chk("ready drained", 16'h1, {15'h0, sample_ready});
        chk("notes left", 16'h0, 16'(expq.size()));
        report_and_stop();
    end
endmodule // tb
